// ===== design/asctl_host.sv
// Purpose: host controller driving an asynchronous 128K x 16 static memory
// Assumes: one request at a time; pins registered; read data pins double synchronised
// Notes: every phase held for whole cycles so each least time is met with margin
`timescale 1ns/1ps
`default_nettype none
module asctl_host (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic req_valid_i,
	input wire asctl_pkg::asctl_req_s req_i,
	output logic req_ready_o,
	output logic rdata_valid_o,
	output logic [asctl_pkg::DATA_W-1:0] rdata_o,
	input wire logic retention_req_i,
	output logic retention_ok_o,
	output logic [asctl_pkg::ADDR_W-1:0] mem_addr_o,
	output asctl_pkg::asctl_ctl_s mem_ctl_o,
	input wire logic [asctl_pkg::DATA_W-1:0] mem_dq_i,
	output logic [asctl_pkg::DATA_W-1:0] mem_dq_o,
	output logic [1:0] mem_dq_oe_o
);
	import asctl_pkg::*;
	asctl_state_e state_reg, state_next;
	asctl_req_s cur_reg, cur_next;
	asctl_ctl_s ctl_reg, ctl_next;
	logic [1:0] dq_oe_reg, dq_oe_next;
	logic [DATA_W-1:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [DATA_W-1:0] dq_s1_reg, dq_s2_reg;
	logic ret_s1_reg, ret_s2_reg;
	logic load;
	logic [3:0] load_val;
	logic done;
	asctl_timer #(.W(4)) u_timer (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.load_i(load),
		.value_i(load_val),
		.done_o(done)
	);
	// lane enable mask from the request's lane picks, high selects
	function automatic logic [DATA_W-1:0] lane_mask(input logic [1:0] lanes);
		return {{8{lanes[1]}}, {8{lanes[0]}}};
	endfunction : lane_mask
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			ret_s1_reg <= 1'b0;
			ret_s2_reg <= 1'b0;
		end
		else
		begin
			dq_s1_reg <= mem_dq_i;
			dq_s2_reg <= dq_s1_reg;
			ret_s1_reg <= retention_req_i;
			ret_s2_reg <= ret_s1_reg;
		end
	end
	always_comb
	begin
		state_next = state_reg;
		cur_next = cur_reg;
		ctl_next = ctl_reg;
		dq_oe_next = dq_oe_reg;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		load = 1'b0;
		load_val = CNT_RESET;
		case (state_reg)
			ST_IDLE:
			begin
				ctl_next = CTL_IDLE;
				dq_oe_next = 2'b00;
				if (ret_s2_reg)
					state_next = ST_RET;
				else if (req_valid_i && req_i.lanes != 2'b00)
				begin
					cur_next = req_i;
					state_next = req_i.we ? ST_WR : ST_RD;
					// address and selects launch in the same edge
					ctl_next.ce_n = 1'b0;
					ctl_next.upper_byte_sel_n = ~req_i.lanes[1];
					ctl_next.lower_byte_sel_n = ~req_i.lanes[0];
					ctl_next.we_n = ~req_i.we;
					ctl_next.oe_n = req_i.we;
					dq_oe_next = req_i.we ? req_i.lanes : 2'b00;
					load = 1'b1;
					// two extra cycles cover the two-flop data synchroniser
					load_val = req_i.we ? 4'(WE_CYC) : 4'(ACCESS_CYC + 2);
				end
			end
			ST_RD:
				if (done)
				begin
					rdata_next = dq_s2_reg & lane_mask(cur_reg.lanes);
					rvalid_next = 1'b1;
					ctl_next = CTL_IDLE;
					load = 1'b1;
					load_val = 4'(TURN_CYC);
					state_next = ST_TURN;
				end
			ST_WR:
				if (done)
				begin
					// strobe, select and lanes end together; data still driven
					ctl_next = CTL_IDLE;
					load = 1'b1;
					load_val = 4'(WRITE_CYC - WE_CYC);
					state_next = ST_TURN;
				end
			ST_TURN:
			begin
				dq_oe_next = 2'b00;
				if (done)
					state_next = ST_IDLE;
			end
			ST_RET:
			begin
				ctl_next = CTL_IDLE;
				if (!ret_s2_reg)
				begin
					load = 1'b1;
					load_val = 4'(RECOVER_CYC);
					state_next = ST_RECOVER;
				end
			end
			ST_RECOVER:
				if (done)
					state_next = ST_IDLE;
			default:
				state_next = ST_IDLE;
		endcase
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			ctl_reg <= CTL_IDLE;
			dq_oe_reg <= 2'b00;
			rdata_reg <= '0;
			rvalid_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			cur_reg <= cur_next;
			ctl_reg <= ctl_next;
			dq_oe_reg <= dq_oe_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
		end
	end
	assign req_ready_o = (state_reg == ST_IDLE) && !ret_s2_reg;
	assign retention_ok_o = (state_reg == ST_RET) && ctl_reg.ce_n;
	assign rdata_o = rdata_reg;
	assign rdata_valid_o = rvalid_reg;
	assign mem_addr_o = cur_reg.addr;
	assign mem_ctl_o = ctl_reg;
	assign mem_dq_o = cur_reg.wdata;
	assign mem_dq_oe_o = dq_oe_reg;

	a_wr_overlap: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(dq_oe_reg != 2'b00) |-> ctl_reg.oe_n)
		else $error("data driven while output drive asserted");
	a_no_contend: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!(ctl_reg.oe_n == 1'b0 && dq_oe_reg != 2'b00))
		else $error("bus contention");
	sequence s_wr_start;
		$fell(ctl_reg.we_n);
	endsequence
	a_we_width: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		s_wr_start |-> (!ctl_reg.we_n)[*2])
		else $error("write strobe too short");
	a_wdata_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(ctl_reg.we_n) |-> dq_oe_reg == $past(dq_oe_reg) && $stable(mem_dq_o))
		else $error("write data not held to strobe end");
	a_addr_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!ctl_reg.ce_n && !$past(ctl_reg.ce_n) |-> $stable(mem_addr_o))
		else $error("address moved inside access");
	a_rd_spacing: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$fell(ctl_reg.oe_n) |-> (!ctl_reg.oe_n)[*4])
		else $error("read cycle too short");
	a_lanes_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		ctl_reg.ce_n |-> ctl_reg.upper_byte_sel_n && ctl_reg.lower_byte_sel_n)
		else $error("lane select active while deselected");
	a_rd_strobe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!ctl_reg.oe_n |-> ctl_reg.we_n)
		else $error("write strobe low during read");
	a_recover: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		(state_reg == ST_RET) ##1 (state_reg == ST_RECOVER) |-> ctl_reg.ce_n[*2])
		else $error("access too soon after retention");
	a_wr_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		!ctl_reg.we_n |-> !ctl_reg.ce_n && !(ctl_reg.upper_byte_sel_n && ctl_reg.lower_byte_sel_n))
		else $error("write strobe without select and lane");
	a_addr_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
		$rose(ctl_reg.we_n) |-> $stable(mem_addr_o))
		else $error("address moved at write end");
endmodule : asctl_host
`default_nettype wire

// ===== design/asctl_pkg.sv
// Purpose: shared constants and carriers for the async static-memory host controller
// Assumes: 40 MHz system clock, 25 ns period
// Notes: times in ns as printed, cycle counts derived from them
package asctl_pkg;
	localparam int CLK_PERIOD_NS = 25;
	localparam int ADDR_W = 17;
	localparam int DATA_W = 16;
	// least times round up, never below one cycle
	localparam int READ_CYCLE_MIN_NS = 45;
	localparam int ACCESS_MAX_NS = 45;
	localparam int WRITE_CYCLE_MIN_NS = 45;
	localparam int WE_PULSE_MIN_NS = 35;
	localparam int DATA_SETUP_NS = 25;
	localparam int OUT_OFF_MAX_NS = 18;
	localparam int RECOVERY_AFTER_RETENTION_NS = 45;
	function automatic int ns_to_cyc(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : ns_to_cyc
	localparam int READ_CYC = ns_to_cyc(READ_CYCLE_MIN_NS);
	localparam int ACCESS_CYC = ns_to_cyc(ACCESS_MAX_NS);
	localparam int WE_CYC = ns_to_cyc(WE_PULSE_MIN_NS);
	localparam int WRITE_CYC = ns_to_cyc(WRITE_CYCLE_MIN_NS);
	localparam int TURN_CYC = ns_to_cyc(OUT_OFF_MAX_NS);
	localparam int RECOVER_CYC = ns_to_cyc(RECOVERY_AFTER_RETENTION_NS);
	localparam logic [3:0] CNT_RESET = 4'h0;
	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [1:0] lanes;
		logic [DATA_W-1:0] wdata;
	} asctl_req_s;
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic upper_byte_sel_n;
		logic lower_byte_sel_n;
	} asctl_ctl_s;
	localparam asctl_ctl_s CTL_IDLE = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
		upper_byte_sel_n: 1'b1, lower_byte_sel_n: 1'b1};
	typedef enum logic [2:0] {ST_IDLE, ST_RD, ST_WR, ST_TURN, ST_RET, ST_RECOVER} asctl_state_e;
endpackage : asctl_pkg

// ===== design/asctl_timer.sv
// Purpose: down counter that times each bus phase
// Assumes: load and count share one clock
// Notes: done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module asctl_timer #(
	parameter int W = 4
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic load_i,
	input wire logic [W-1:0] value_i,
	output logic done_o
);
	logic [W-1:0] cnt_reg;
	logic [W-1:0] cnt_next;
	always_comb
	begin
		cnt_next = cnt_reg;
		if (load_i)
			cnt_next = value_i;
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - 1'b1;
	end
	always_ff @(posedge sys_clk_i)
	begin
		if (rst_i)
			cnt_reg <= '0;
		else
			cnt_reg <= cnt_next;
	end
	assign done_o = (cnt_reg == '0);
endmodule : asctl_timer
`default_nettype wire

// ===== tb/asctl_sram_model.sv
// Purpose: behavioural async static memory facing the host
// Assumes: level-sensitive write, no clock
// Notes: lanes not driven show inverted data, never a held value
`timescale 1ns/1ps
`default_nettype none
module asctl_sram_model #(
	parameter int ACC_NS = 40
) (
	input wire logic [asctl_pkg::ADDR_W-1:0] addr_i,
	input wire asctl_pkg::asctl_ctl_s ctl_i,
	input wire logic [asctl_pkg::DATA_W-1:0] wdata_i,
	input wire logic [1:0] host_oe_i,
	output logic [asctl_pkg::DATA_W-1:0] dq_o,
	output logic clash_o
);
	import asctl_pkg::*;
	logic [DATA_W-1:0] mem [0:131071];
	logic [1:0] lane;
	logic [DATA_W-1:0] mask;
	logic wr;
	logic rd;
	logic wr_late;
	logic [1:0] drv;
	assign lane = {~ctl_i.upper_byte_sel_n, ~ctl_i.lower_byte_sel_n};
	assign wr = ~ctl_i.ce_n & ~ctl_i.we_n & (|lane);
	assign rd = ~ctl_i.ce_n & ctl_i.we_n & ~ctl_i.oe_n;
	assign mask = rd ? {{8{lane[1]}}, {8{lane[0]}}} : 16'h0000;
	// slow side of the access limits, so early sampling shows up
	assign #(ACC_NS) dq_o = mask ~^ mem[addr_i];
	// lanes drive 5 ns after a read opens and let go 18 ns after it closes
	assign #(5, 18) drv = {rd, rd} & lane;
	assign clash_o = |(drv & host_oe_i);
	// late strobe copy: a same-step address change must not be written
	assign #1 wr_late = wr;
	// a lane the host leaves undriven stores inverted data
	always @(wr or wr_late or lane or addr_i or wdata_i or host_oe_i)
	begin
		if (wr && wr_late && lane[0])
			mem[addr_i][7:0] = host_oe_i[0] ? wdata_i[7:0] : ~wdata_i[7:0];
		if (wr && wr_late && lane[1])
			mem[addr_i][15:8] = host_oe_i[1] ? wdata_i[15:8] : ~wdata_i[15:8];
	end
endmodule : asctl_sram_model
`default_nettype wire

// ===== tb/asctl_host_tb.sv
// Purpose: self-checking bench for the static-memory host
// Assumes: inputs change on rising edges, outputs read on falling
// Notes: memory model answers slowly
`timescale 1ns/1ps
`default_nettype none
module asctl_host_tb;
	import asctl_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid = 1'b0;
	asctl_req_s req = '0;
	logic ret_req = 1'b0;
	logic ready, rvalid, ret_ok, clash;
	logic [DATA_W-1:0] rdata, dq_o, dq_i;
	logic [ADDR_W-1:0] addr;
	asctl_ctl_s ctl;
	logic [1:0] dq_oe;
	logic [1:0] prev_oe = 2'h0;
	logic prev_we = 1'b1;
	int wlow = 0;
	int mismatches = 0;
	int cmp_count = 0;
	asctl_host DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid), .req_i(req),
		.req_ready_o(ready), .rdata_valid_o(rvalid), .rdata_o(rdata), .retention_req_i(ret_req),
		.retention_ok_o(ret_ok), .mem_addr_o(addr), .mem_ctl_o(ctl), .mem_dq_i(dq_i),
		.mem_dq_o(dq_o), .mem_dq_oe_o(dq_oe));
	asctl_sram_model MEM (.addr_i(addr), .ctl_i(ctl), .wdata_i(dq_o), .host_oe_i(dq_oe),
		.dq_o(dq_i), .clash_o(clash));
	initial
	begin
		forever #12.5 sys_clk_i = ~sys_clk_i;
	end
	task automatic chk(input logic ok, input string msg);
		cmp_count++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : conclude
	always @(negedge sys_clk_i)
	begin
		if (!rst_i)
		begin
			chk(!clash, "bus clash");
			if (ctl.we_n && !prev_we)
			begin
				chk(wlow >= WE_CYC, "short strobe");
				chk(dq_oe === prev_oe, "data dropped at write end");
			end
		end
		wlow = ctl.we_n ? 0 : wlow + 1;
		prev_we = ctl.we_n;
		prev_oe = dq_oe;
	end
	task automatic wait_lo(ref logic s);
		int n;
		n = 0;
		while (s !== 1'b1 && n < 40)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		chk(s === 1'b1, "wait limit");
	endtask : wait_lo
	task automatic issue(input logic we, input logic [ADDR_W-1:0] a, input logic [1:0] ln,
		input logic [DATA_W-1:0] d);
		@(posedge sys_clk_i);
		req_valid <= 1'b1;
		req <= '{we: we, addr: a, lanes: ln, wdata: d};
		@(negedge sys_clk_i);
		wait_lo(ready);
		@(posedge sys_clk_i);
		req_valid <= 1'b0;
		@(negedge sys_clk_i);
		chk(ready === 1'b0, "not busy");
	endtask : issue
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [1:0] ln, input logic [15:0] d);
		logic [DATA_W-1:0] m;
		m = {{8{ln[1]}}, {8{ln[0]}}};
		issue(1'b1, a, ln, d);
		@(negedge sys_clk_i);
		chk(ctl.we_n === 1'b0 && addr === a && dq_oe === ln, "write pins");
		chk((dq_o & m) === (d & m), "write data");
	endtask : wr
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [1:0] ln, input logic [15:0] e);
		int n;
		issue(1'b0, a, ln, 16'h0000);
		chk(ctl.ce_n === 1'b0 && ctl.oe_n === 1'b0 && ctl.we_n === 1'b1 && addr === a, "read pins");
		n = 1;
		while (rvalid !== 1'b1 && n < 20)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		chk(n == 6, "read latency");
		chk(rdata === e, "read data");
	endtask : rd
	task automatic t_empty();
		@(posedge sys_clk_i);
		req_valid <= 1'b1;
		req <= '{we: 1'b1, addr: 17'h00010, lanes: 2'h0, wdata: 16'hFFFF};
		repeat (4) @(negedge sys_clk_i);
		chk(ctl === CTL_IDLE && ready === 1'b1, "empty lanes taken");
		@(posedge sys_clk_i);
		req_valid <= 1'b0;
	endtask : t_empty
	task automatic t_retain();
		time t0;
		int n;
		@(posedge sys_clk_i);
		ret_req <= 1'b1;
		wait_lo(ret_ok);
		chk(ret_ok === 1'b1 && ctl.ce_n === 1'b1 && ready === 1'b0, "retention entry");
		@(posedge sys_clk_i);
		ret_req <= 1'b0;
		n = 0;
		// recovery counts from the supply-restored point, not from the request drop
		while (ret_ok !== 1'b0 && n < 40)
		begin
			@(negedge sys_clk_i);
			n++;
		end
		t0 = $time;
		wait_lo(ready);
		chk(($time - t0) >= RECOVERY_AFTER_RETENTION_NS, "recovery too short");
	endtask : t_retain
	initial
	begin
		repeat (8) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		@(negedge sys_clk_i);
		chk(ctl === CTL_IDLE && dq_oe === 2'h0 && rvalid === 1'b0 && rdata === 16'h0000
			&& ready === 1'b1, "reset state");
		wr(17'h1FFFF, 2'h3, 16'hA55A);
		rd(17'h1FFFF, 2'h3, 16'hA55A);
		wr(17'h00010, 2'h1, 16'h1234);
		wr(17'h00010, 2'h2, 16'hCDEF);
		rd(17'h00010, 2'h1, 16'h0034);
		rd(17'h00010, 2'h2, 16'hCD00);
		t_empty();
		rd(17'h00010, 2'h3, 16'hCD34);
		t_retain();
		rd(17'h1FFFF, 2'h3, 16'hA55A);
		conclude();
	end
	initial
	begin
		#100000;
		mismatches++;
		conclude();
	end
endmodule : asctl_host_tb
`default_nettype wire
